// *** src/ibsf_pkg.sv ***
package ibsf_pkg;

  typedef logic [31:0] ibsf_word_t;
  typedef logic [1:0] ibsf_resp_t;

  // Register index as printed; byte address is four times it
  localparam ibsf_word_t FLAGS_INDEX = 32'h0FFFFD86;
  localparam ibsf_word_t FLAGS_ADDR = {FLAGS_INDEX[29:0], 2'b00};
  localparam ibsf_word_t CTRL_ADDR = 32'h00000000;
  localparam ibsf_word_t LADDR_ADDR = 32'h00000004;
  localparam ibsf_word_t TXD_ADDR = 32'h00000008;
  localparam ibsf_word_t IRQ_STAT_ADDR = 32'h0000000C;
  localparam ibsf_word_t IRQ_MASK_ADDR = 32'h00000010;
  localparam ibsf_word_t BIT_BASE_ADDR = 32'h00000020;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Control register fields
  localparam int CTRL_OP_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_EXIT = 2;
  localparam int CTRL_WREL = 3;

  // Interrupt status and mask fields
  localparam int IRQ_W = 5;
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_ARB = 2;
  localparam int IRQ_MATCH = 3;
  localparam int IRQ_WAIT = 4;

  // Clock counts within a byte
  localparam logic [3:0] CNT_EIGHTH = 4'h7;
  localparam logic [3:0] CNT_NINTH = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;

  localparam ibsf_resp_t RESP_OKAY = 2'h0;
  localparam ibsf_resp_t RESP_SLVERR = 2'h2;

  // Bit 7 down to bit 0 of the status byte
  typedef struct packed {
    logic master_active_flag;
    logic arb_lost_flag;
    logic ext_code_flag;
    logic addr_match_flag;
    logic tx_direction_flag;
    logic ack_seen_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
  } ibsf_flags_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACTIVE,
    BUS_WAIT,
    BUS_DETACHED
  } ibsf_bus_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    ibsf_bus_t bus;
    ibsf_flags_t flags;
    logic [3:0] bit_cnt;
    logic [6:0] rx;
    logic first_byte;
    logic start_pend;
    logic op_en;
    logic [6:0] laddr;
    logic [7:0] txd;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic pin_lvl;
    logic scl_oe_n;
    logic sda_oe_n;
    logic have_aw;
    logic have_w;
    logic awready;
    logic wready;
    ibsf_word_t aw_addr;
    ibsf_word_t wdata;
    logic [3:0] wstrb;
    logic bvalid;
    ibsf_resp_t bresp;
    logic arready;
    logic rvalid;
    ibsf_resp_t rresp;
    ibsf_word_t rdata;
  } ibsf_state_t;

endpackage

// *** src/ibsf_status.sv ***
`timescale 1ns/1ns
module ibsf_status
  import ibsf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire ibsf_pkg::ibsf_word_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire ibsf_pkg::ibsf_word_t wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output ibsf_pkg::ibsf_resp_t bresp,
  input wire logic arvalid,
  output logic arready,
  input wire ibsf_pkg::ibsf_word_t araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output ibsf_pkg::ibsf_word_t rdata,
  output ibsf_pkg::ibsf_resp_t rresp,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n,
  output logic irq
);
  import ibsf_pkg::*;

  ibsf_state_t q;
  ibsf_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic wr_fire;
  logic rd_fire;
  logic flag_rd;
  logic start_cmd;
  logic exit_cmd;
  logic wrel_cmd;
  logic op_fall;
  logic sda_now;
  logic [7:0] rx_full;
  logic [3:0] nxt_cnt;
  logic data_en;
  logic ack_en;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  ibsf_word_t rd_val;
  ibsf_resp_t rd_resp;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d = q;
    ev = '0;
    w1c = '0;
    start_cmd = 1'b0;
    exit_cmd = 1'b0;
    wrel_cmd = 1'b0;
    rd_val = '0;
    rd_resp = RESP_OKAY;
    rx_full = '0;
    nxt_cnt = q.bit_cnt;
    data_en = 1'b0;
    ack_en = 1'b0;

    // Pins are asynchronous; only the second stage onward is looked at
    d.scl_s1 = serial_clock_pin_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = serial_data_pin_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    sda_now = q.sda_s2;
    scl_rise = q.scl_s2 & ~q.scl_s3;
    scl_fall = ~q.scl_s2 & q.scl_s3;
    start_det = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    stop_det = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;

    //////////////////////////////////////////////////////////////////////////
    // Register bus: address and data may arrive in either order
    if (awvalid && q.awready)
    begin
      d.have_aw = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready)
    begin
      d.have_w = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    wr_fire = q.have_aw & q.have_w & ~q.bvalid;
    if (wr_fire)
    begin
      d.have_aw = 1'b0;
      d.have_w = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (q.aw_addr)
        CTRL_ADDR:
        begin
          if (q.wstrb[0])
          begin
            d.op_en = q.wdata[CTRL_OP_EN];
            start_cmd = q.wdata[CTRL_START];
            exit_cmd = q.wdata[CTRL_EXIT];
            wrel_cmd = q.wdata[CTRL_WREL];
          end
        end
        LADDR_ADDR:
        begin
          if (q.wstrb[0])
            d.laddr = q.wdata[6:0];
        end
        TXD_ADDR:
        begin
          if (q.wstrb[0])
            d.txd = q.wdata[7:0];
        end
        IRQ_STAT_ADDR:
        begin
          if (q.wstrb[0])
            w1c = q.wdata[IRQ_W-1:0];
        end
        IRQ_MASK_ADDR:
        begin
          if (q.wstrb[0])
            d.irq_mask = q.wdata[IRQ_W-1:0];
        end
        FLAGS_ADDR:
          d.bresp = RESP_OKAY;
        default:
        begin
          if (q.aw_addr[31:5] != BIT_BASE_ADDR[31:5])
            d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;
    d.awready = ~d.have_aw;
    d.wready = ~d.have_w;

    flag_rd = 1'b0;
    case (araddr)
      FLAGS_ADDR:
      begin
        rd_val = {24'h000000, q.flags};
        flag_rd = 1'b1;
      end
      CTRL_ADDR:
        rd_val = {28'h0000000, 2'h0, q.start_pend, q.op_en};
      LADDR_ADDR:
        rd_val = {25'h0000000, q.laddr};
      TXD_ADDR:
        rd_val = {24'h000000, q.txd};
      IRQ_STAT_ADDR:
        rd_val = {27'h0000000, q.irq_stat};
      IRQ_MASK_ADDR:
        rd_val = {27'h0000000, q.irq_mask};
      default:
      begin
        if (araddr[31:5] == BIT_BASE_ADDR[31:5] && araddr[1:0] == 2'h0)
        begin
          rd_val = {31'h00000000, q.flags[araddr[4:2]]};
          flag_rd = 1'b1;
        end
        else
          rd_resp = RESP_SLVERR;
      end
    endcase
    rd_fire = arvalid & q.arready;
    if (rd_fire)
    begin
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_resp;
    end
    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    d.arready = ~d.rvalid;

    if (rd_fire && flag_rd)
      d.flags.arb_lost_flag = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // Bus side
    if (start_cmd)
      d.start_pend = 1'b1;
    if (exit_cmd)
    begin
      d.flags.master_active_flag = 1'b0;
      d.flags.ext_code_flag = 1'b0;
      d.flags.addr_match_flag = 1'b0;
      d.flags.tx_direction_flag = 1'b0;
      d.flags.ack_seen_flag = 1'b0;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
      if (q.bus != BUS_IDLE)
        d.bus = BUS_DETACHED;
    end

    case (q.bus)
      BUS_IDLE:
      begin
        // Start is pulled only on a free bus with the clock high
        if (q.start_pend && q.scl_s2 && q.sda_s2)
          d.sda_oe_n = 1'b0;
      end
      BUS_ACTIVE:
      begin
        if (scl_rise)
        begin
          nxt_cnt = q.bit_cnt + 4'h1;
          d.bit_cnt = nxt_cnt;
          if (q.bit_cnt < CNT_EIGHTH)
            d.rx = {q.rx[5:0], sda_now};
          if (q.bit_cnt == 4'h0)
            d.flags.ack_seen_flag = 1'b0;
          rx_full = {q.rx, sda_now};
          if (q.bit_cnt == CNT_EIGHTH && q.first_byte)
          begin
            if (rx_full[7:4] == 4'h0 || rx_full[7:4] == 4'hF)
              d.flags.ext_code_flag = 1'b1;
            if (q.rx == q.laddr)
            begin
              d.flags.addr_match_flag = 1'b1;
              ev[IRQ_MATCH] = 1'b1;
              if (!q.flags.master_active_flag)
                d.flags.tx_direction_flag = sda_now;
            end
            if (q.flags.master_active_flag)
              d.flags.tx_direction_flag = ~sda_now;
          end
          if (q.bit_cnt == CNT_NINTH)
          begin
            d.flags.ack_seen_flag = ~sda_now;
            d.first_byte = 1'b0;
          end
          if (q.flags.master_active_flag && q.flags.tx_direction_flag &&
              q.bit_cnt < CNT_NINTH && q.sda_oe_n && !sda_now)
          begin
            d.flags.arb_lost_flag = 1'b1;
            d.flags.master_active_flag = 1'b0;
            d.flags.tx_direction_flag = 1'b0;
            d.bus = BUS_DETACHED;
            ev[IRQ_ARB] = 1'b1;
          end
        end
        if (scl_fall)
        begin
          if (q.bit_cnt == CNT_DONE)
          begin
            nxt_cnt = 4'h0;
            d.bit_cnt = 4'h0;
            // Hold the clock low so software can read safely
            if (d.flags.master_active_flag || d.flags.addr_match_flag)
            begin
              d.bus = BUS_WAIT;
              d.scl_oe_n = 1'b0;
              ev[IRQ_WAIT] = 1'b1;
            end
          end
          data_en = d.flags.tx_direction_flag && nxt_cnt < CNT_NINTH &&
                    (d.flags.master_active_flag || !d.first_byte);
          // A matched slave acknowledges its address in either direction
          if (d.first_byte)
            ack_en = nxt_cnt == CNT_NINTH && d.flags.addr_match_flag &&
                     !d.flags.master_active_flag;
          else
            ack_en = nxt_cnt == CNT_NINTH && !d.flags.tx_direction_flag &&
                     (d.flags.addr_match_flag || d.flags.master_active_flag);
          d.sda_oe_n = ~((data_en && !q.txd[3'(CNT_EIGHTH - nxt_cnt)]) ||
                         ack_en);
        end
      end
      BUS_WAIT:
      begin
        if (wrel_cmd)
        begin
          d.bus = BUS_ACTIVE;
          d.scl_oe_n = 1'b1;
        end
      end
      BUS_DETACHED:
        d.sda_oe_n = 1'b1;
      default:
        d.bus = BUS_IDLE;
    endcase

    if (start_det)
    begin
      if (q.start_pend && !q.sda_oe_n)
      begin
        d.flags.master_active_flag = 1'b1;
        d.flags.tx_direction_flag = 1'b1;
      end
      else
      begin
        d.flags.tx_direction_flag = 1'b0;
        if (q.start_pend)
        begin
          d.flags.arb_lost_flag = 1'b1;
          d.flags.master_active_flag = 1'b0;
          ev[IRQ_ARB] = 1'b1;
        end
      end
      d.start_pend = 1'b0;
      d.flags.start_seen_flag = 1'b1;
      d.flags.stop_seen_flag = 1'b0;
      d.flags.ext_code_flag = 1'b0;
      d.flags.addr_match_flag = 1'b0;
      d.bit_cnt = 4'h0;
      d.first_byte = 1'b1;
      d.bus = BUS_ACTIVE;
      ev[IRQ_START] = 1'b1;
    end
    if (stop_det)
    begin
      d.flags.master_active_flag = 1'b0;
      d.flags.ext_code_flag = 1'b0;
      d.flags.addr_match_flag = 1'b0;
      d.flags.tx_direction_flag = 1'b0;
      d.flags.ack_seen_flag = 1'b0;
      d.flags.start_seen_flag = 1'b0;
      d.flags.stop_seen_flag = 1'b1;
      d.bus = BUS_IDLE;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
      ev[IRQ_STOP] = 1'b1;
    end

    op_fall = q.op_en & ~d.op_en;
    if (op_fall || !d.op_en)
    begin
      d.flags = FLAGS_RESET;
      d.bus = BUS_IDLE;
      d.start_pend = 1'b0;
      d.scl_oe_n = 1'b1;
      d.sda_oe_n = 1'b1;
      ev = '0;
    end

    // New events win over a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~w1c) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);
    d.pin_lvl = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
    end
    else
      q <= d;
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign serial_clock_pin_o = q.pin_lvl;
  assign serial_clock_pin_oe_n = q.scl_oe_n;
  assign serial_data_pin_o = q.pin_lvl;
  assign serial_data_pin_oe_n = q.sda_oe_n;
  assign irq = q.irq;

endmodule

// *** test/ibsf_status_assertions.sv ***
`timescale 1ns/1ns
module ibsf_status_assertions
  import ibsf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire ibsf_pkg::ibsf_word_t awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire ibsf_pkg::ibsf_resp_t bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire ibsf_pkg::ibsf_word_t araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire ibsf_pkg::ibsf_word_t rdata,
  input wire ibsf_pkg::ibsf_resp_t rresp,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_n,
  input wire logic irq
);
  ibsf_word_t ar_q;
  ibsf_word_t aw_q;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Answers come later than the request, so keep its address
  always_ff @(posedge aclk)
  begin
    if (arvalid && arready)
      ar_q <= araddr;
    if (awvalid && awready)
      aw_q <= awaddr;
  end
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (s_rd_take |=> rvalid)
    else $error("read not answered");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_bit_window: assert property (rvalid && ar_q[31:5] == BIT_BASE_ADDR[31:5]
    |-> rdata[31:1] == 31'h0 && rresp == RESP_OKAY)
    else $error("bit window wider than one bit");
  a_status_byte: assert property (rvalid && ar_q == FLAGS_ADDR
    |-> rdata[31:8] == 24'h0 && rresp == RESP_OKAY)
    else $error("status wider than a byte");
  a_write_answer: assert property (s_wr_take |-> ##[1:3] bvalid)
    else $error("write not answered");
  a_status_wr_ok: assert property (bvalid && aw_q == FLAGS_ADDR
    |-> bresp == RESP_OKAY)
    else $error("status write refused");
  a_reset_quiet: assert property ($rose(aresetn)
    |-> !rvalid && !bvalid && !irq && serial_data_pin_oe_n)
    else $error("outputs busy after reset");
  a_data_pulls_low: assert property (!serial_data_pin_oe_n
    |-> !serial_data_pin_o)
    else $error("data line driven high");
endmodule
bind ibsf_status ibsf_status_assertions chk (.*);

// *** test/ibsf_bus_peer.sv ***
`timescale 1ns/1ns
module ibsf_bus_peer (
  input wire logic scl_oe_n,
  input wire logic scl_o,
  input wire logic sda_oe_n,
  input wire logic sda_o,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // Pull-ups: a released line reads high, any driver low wins
  assign scl = scl_q & (scl_oe_n | scl_o);
  assign sda = sda_q & (sda_oe_n | sda_o);
  ////////////////////////////////////////////////////////////////////////////
  // Clock is 400 ns; a held-low clock stretches the low phase
  task automatic put_bit(input logic b);
    scl_q <= 1'b0;
    #100 sda_q <= b;
    #100 scl_q <= 1'b1;
    for (int i = 0; i < 400 && scl !== 1'b1; i++)
      #50;
    #200;
  endtask
  task automatic start_cond();
    put_bit(1'b1);
    sda_q <= 1'b0;
    #200;
  endtask
  task automatic stop_cond();
    put_bit(1'b0);
    sda_q <= 1'b1;
    #200;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    put_bit(1'b1);
    scl_q <= 1'b0;
    #100;
  endtask
endmodule

// *** test/test_ibsf_status.sv ***
`timescale 1ns/1ns
module test_ibsf_status;
  import ibsf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] awprot = 3'h0;
  logic [2:0] arprot = 3'h0;
  logic [3:0] wstrb = 4'hF;
  ibsf_word_t awaddr = 32'h0;
  ibsf_word_t wdata = 32'h0;
  ibsf_word_t araddr = 32'h0;
  ibsf_word_t rdata;
  ibsf_resp_t bresp;
  ibsf_resp_t rresp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_n;
  logic serial_data_pin_i, serial_data_pin_o, serial_data_pin_oe_n;
  int bad_count = 0;
  int samples_checked = 0;
  always #25 aclk = ~aclk;
  ibsf_status dut (.*);
  ibsf_bus_peer peer (.scl_oe_n(serial_clock_pin_oe_n),
    .scl_o(serial_clock_pin_o), .sda_oe_n(serial_data_pin_oe_n),
    .sda_o(serial_data_pin_o), .scl(serial_clock_pin_i),
    .sda(serial_data_pin_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, wrong %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic axi_write(input ibsf_word_t addr, input ibsf_word_t data);
    int n;
    @(posedge aclk);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && bvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 100) bad_count++;
    if (n == 100) complete_run();
  endtask
  task automatic axi_read(input ibsf_word_t addr, output ibsf_word_t d,
    output ibsf_resp_t r);
    int n;
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && rvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 100) bad_count++;
    if (n == 100) complete_run();
  endtask
  task automatic expect_rd(input ibsf_word_t a, input ibsf_word_t m,
    input ibsf_word_t w);
    ibsf_word_t d;
    ibsf_resp_t r;
    axi_read(a, d, r);
    check(d & m, w);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    ibsf_word_t d;
    ibsf_resp_t r;
    expect_rd(FLAGS_ADDR, 32'hFFFFFFFF, 32'h0);
    axi_write(FLAGS_ADDR, 32'h000000FF);
    expect_rd(FLAGS_ADDR, 32'hFFFFFFFF, 32'h0);
    axi_read(32'h00000100, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    $display("reset test done");
  endtask
  task automatic t_slave_match();
    axi_write(CTRL_ADDR, 32'h00000001);
    axi_write(LADDR_ADDR, 32'h00000005);
    axi_write(TXD_ADDR, 32'h000000FF);
    peer.start_cond();
    peer.send_byte(8'h0B);
    expect_rd(FLAGS_ADDR, 32'hFF, 32'h3E);
    for (int n = 0; n < 8; n++)
      expect_rd(BIT_BASE_ADDR + 32'(4 * n), 32'hFF, 32'((8'h3E >> n) & 1));
    check({31'h0, irq}, 32'h0);
    expect_rd(IRQ_STAT_ADDR, 32'h8, 32'h8);
    axi_write(CTRL_ADDR, 32'h00000009);
    peer.stop_cond();
    expect_rd(FLAGS_ADDR, 32'hF9, 32'h01);
    $display("slave match test done");
  endtask
  task automatic t_arb_loss();
    axi_write(IRQ_MASK_ADDR, 32'h00000004);
    // Second pass clears through a single-bit read of another bit
    for (int k = 0; k < 2; k++)
    begin
      peer.start_cond();
      peer.send_byte(8'hA0);
      axi_write(CTRL_ADDR, 32'h00000003);
      peer.start_cond();
      check({31'h0, irq}, 32'h1);
      expect_rd(k ? BIT_BASE_ADDR : FLAGS_ADDR, k ? 32'h1 : 32'hC0,
        k ? 32'h0 : 32'h40);
      expect_rd(FLAGS_ADDR, 32'hC0, 32'h0);
      axi_write(IRQ_STAT_ADDR, 32'h00000004);
      repeat (2) @(negedge aclk);
      check({31'h0, irq}, 32'h0);
      peer.stop_cond();
    end
    $display("arbitration test done");
  endtask
  task automatic t_master();
    ibsf_word_t d = 32'h0;
    ibsf_resp_t r;
    axi_write(CTRL_ADDR, 32'h00000003);
    for (int n = 0; n < 20 && d[7] !== 1'b1; n++)
      axi_read(FLAGS_ADDR, d, r);
    check(d, 32'h8A);
    axi_write(CTRL_ADDR, 32'h00000005);
    expect_rd(FLAGS_ADDR, 32'hB0, 32'h0);
    peer.stop_cond();
    axi_write(CTRL_ADDR, 32'h0);
    expect_rd(FLAGS_ADDR, 32'hFF, 32'h0);
    $display("master test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_regs();
    t_slave_match();
    t_arb_loss();
    t_master();
    complete_run();
  end
  // Peer stretch waits are bounded but silent, so cap the run
  initial
  begin
    #4000000;
    bad_count++;
    complete_run();
  end
endmodule
